// >>> lcdd_ctrl.sv
// Segment LCD driver controller with AXI4-Lite registers.
//
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module lcdd_ctrl
  import lcdd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sleep_req,
  input wire logic timer_one_oscillator_clk,
  input wire logic lfosc_clk,
  output logic [3:0] com_select,
  output logic com_phase,
  output logic [SEG_W-1:0] seg_level,
  output logic [SEG_W-1:0] seg_pin_func,
  output logic bias_half
);

  // Decode a pixel register address into {valid, index}.
  function automatic logic [5:0] pix_slot(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] ofs;
    logic [5:0] idx;
    logic ok;
    ofs = addr - OFS_PIX_BASE;
    idx = ofs[7:2];
    ok = (addr >= OFS_PIX_BASE) && (addr[1:0] == 2'h0);
    if (idx < 6'h0C) begin
      ok = ok && ((idx % 6'h03) != 6'h02);
    end else begin
      ok = ok && (idx < 6'h16) && ((idx % 6'h03) == 6'h00);
    end
    return {ok, idx[4:0]};
  endfunction : pix_slot

  logic [7:0] ctrl_reg;
  logic [7:0] phase_reg;
  logic [7:0] segen_reg [3];
  logic [7:0] pix_reg [PIX_COUNT];
  logic write_error_flag_reg;
  logic [1:0] sleep_sync_reg;
  logic active_reg;
  logic [1:0] com_idx_reg;
  logic phase_bit_reg;
  logic aw_got_reg;
  logic w_got_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [3:0] wstrb_reg;

  logic driver_on;
  logic sleep_disable;
  logic [1:0] common_count_select;
  logic waveform_type_select;
  logic bias_select;
  logic write_allow_flag;
  logic last_com;
  logic [1:0] next_com;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic do_wr;
  logic wr_lane;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [3:0] wr_strb;
  logic [5:0] wr_slot;
  logic [5:0] rd_slot;
  logic wr_pix;
  logic wr_map;
  logic [4:0] row_lo;
  logic [4:0] row_hi;
  logic [4:0] row_ext;
  logic [SEG_W-1:0] cur_pix;
  logic [SEG_W-1:0] func_next;

  lcdd_tick_if tif ();

  // Field views of the control registers.
  assign driver_on = ctrl_reg[CTRL_ON_BIT];
  assign sleep_disable = ctrl_reg[CTRL_SLPDIS_BIT];
  assign common_count_select = ctrl_reg[CTRL_MUX_LSB +: 2];
  assign waveform_type_select = phase_reg[PH_WFT_BIT];
  assign bias_select = phase_reg[PH_BIAS_BIT];

  // Frame position: the last common is the one the count field selects.
  assign last_com = (com_idx_reg >= common_count_select);
  assign next_com = last_com ? 2'h0 : com_idx_reg + 2'h1;

  // Pixel writes are held off in the phase-one step of the last common, so a frame
  // never shows half of an update across its own boundary.
  assign write_allow_flag = ~(active_reg & last_com & phase_bit_reg);

  // Tick generator hookup; it only runs while the driver is active.
  assign tif.src_sel = ctrl_reg[CTRL_CS_LSB +: 2];
  assign tif.ratio = phase_reg[PH_LP_LSB +: 4];
  assign tif.run = active_reg;

  lcdd_tick_gen u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .timer_one_oscillator_clk(timer_one_oscillator_clk),
    .lfosc_clk(lfosc_clk),
    .tif(tif)
  );

  // Write channel: address and data are taken in either order.
  assign s_axi_awready = ~aw_got_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~w_got_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign aw_hs = s_axi_awvalid & s_axi_awready;
  assign w_hs = s_axi_wvalid & s_axi_wready;
  assign ar_hs = s_axi_arvalid & s_axi_arready;
  assign wr_addr = aw_got_reg ? awaddr_reg : s_axi_awaddr;
  assign wr_data = w_got_reg ? wdata_reg : s_axi_wdata;
  assign wr_strb = w_got_reg ? wstrb_reg : s_axi_wstrb;
  assign do_wr = (aw_got_reg | aw_hs) & (w_got_reg | w_hs);
  assign wr_lane = do_wr & wr_strb[0];
  assign wr_slot = pix_slot(wr_addr);
  assign rd_slot = pix_slot(s_axi_araddr);
  assign wr_pix = wr_lane & wr_slot[5];

  // Addresses that hold a register answer OKAY, all others SLVERR.
  always_comb begin
    case (wr_addr)
      OFS_CTRL, OFS_PHASE, OFS_SEGEN0, OFS_SEGEN1, OFS_SEGEN2: wr_map = 1'b1;
      default: wr_map = wr_slot[5];
    endcase
  end

  // Hold whichever half of a write arrived first.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= 4'h0;
    end else if (do_wr) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
    end else begin
      if (aw_hs) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
    end
  end

  // Write response one cycle after both halves are in.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_map ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Configuration registers; only byte lane 0 carries data.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RST;
      phase_reg <= PHASE_RST;
      for (int i = 0; i < 3; i++) begin
        segen_reg[i] <= SEGEN_RST;
      end
    end else if (wr_lane) begin
      case (wr_addr)
        OFS_CTRL: ctrl_reg <= wr_data[7:0] & CTRL_WMASK;
        OFS_PHASE: phase_reg <= wr_data[7:0] & PHASE_WMASK;
        OFS_SEGEN0: segen_reg[0] <= wr_data[7:0];
        OFS_SEGEN1: segen_reg[1] <= wr_data[7:0];
        OFS_SEGEN2: segen_reg[2] <= {5'h00, wr_data[2:0]};
        default: ;
      endcase
    end
  end

  // Error flag: a rejected pixel write sets it and wins over a clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      write_error_flag_reg <= 1'b0;
    end else if (wr_pix && !write_allow_flag) begin
      write_error_flag_reg <= 1'b1;
    end else if (wr_lane && wr_addr == OFS_CTRL
                 && !wr_data[CTRL_WRITE_ERROR_FLAG_BIT]) begin
      write_error_flag_reg <= 1'b0;
    end
  end

  // Pixel store; a write is dropped while writes are not allowed.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < PIX_COUNT; i++) begin
        pix_reg[i] <= PIX_RST;
      end
    end else if (wr_pix && write_allow_flag) begin
      pix_reg[wr_slot[4:0]] <= wr_data[7:0];
    end
  end

  // Read channel: data are captured when the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr)
        OFS_CTRL: s_axi_rdata <= {24'h000000, ctrl_reg[7:6], write_error_flag_reg,
                                  1'b0, ctrl_reg[3:0]};
        OFS_PHASE: s_axi_rdata <= {24'h000000, phase_reg[7:6],
                                   active_reg, write_allow_flag,
                                   phase_reg[3:0]};
        OFS_SEGEN0: s_axi_rdata <= {24'h000000, segen_reg[0]};
        OFS_SEGEN1: s_axi_rdata <= {24'h000000, segen_reg[1]};
        OFS_SEGEN2: s_axi_rdata <= {24'h000000, segen_reg[2]};
        default: begin
          if (rd_slot[5]) begin
            s_axi_rdata <= {24'h000000, pix_reg[rd_slot[4:0]]};
          end else begin
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_SLVERR;
          end
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // The sleep request comes from another domain: two flops first.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleep_sync_reg <= 2'h0;
    end else begin
      sleep_sync_reg <= {sleep_sync_reg[0], sleep_req};
    end
  end

  // Driver runs when enabled, unless asleep with sleep-disable set.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_reg <= 1'b0;
    end else begin
      active_reg <= driver_on
                    & ~(sleep_sync_reg[1] & sleep_disable);
    end
  end

  // Common sequencer. Type-A flips phase halfway through each common;
  // Type-B holds a phase for a whole frame and flips at the wrap.
  always_ff @(posedge aclk) begin
    if (!aresetn || !active_reg) begin
      com_idx_reg <= 2'h0;
      phase_bit_reg <= 1'b0;
    end else if (tif.tick) begin
      if (!waveform_type_select) begin
        if (phase_bit_reg) begin
          phase_bit_reg <= 1'b0;
          com_idx_reg <= next_com;
        end else begin
          phase_bit_reg <= 1'b1;
        end
      end else begin
        com_idx_reg <= next_com;
        if (last_com) begin
          phase_bit_reg <= ~phase_bit_reg;
        end
      end
    end
  end

  // Rows of pixel data for the common now being driven.
  always_comb begin
    row_lo = {3'h0, com_idx_reg} * 5'h03;
    row_hi = row_lo + 5'h01;
    row_ext = row_lo + 5'h0C;
    cur_pix = {pix_reg[row_ext][2:0], 8'h00, pix_reg[row_hi],
               pix_reg[row_lo]};
    func_next = {segen_reg[2][2:0], 8'h00, segen_reg[1], segen_reg[0]};
    if (common_count_select == MUX_QUAD) begin
      func_next[SEG_SHARED] = 1'b0;
    end
  end

  // Pin drive registers. A dark pixel drives its segment against the
  // common phase; an idle driver leaves the common and segment level lines low.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      com_select <= 4'h0;
      com_phase <= 1'b0;
      seg_level <= '0;
      seg_pin_func <= '0;
      bias_half <= 1'b0;
    end else begin
      com_select <= active_reg ? (4'h1 << com_idx_reg) : 4'h0;
      com_phase <= active_reg & phase_bit_reg;
      seg_pin_func <= func_next;
      seg_level <= active_reg ?
                   ((cur_pix ^ {SEG_W{phase_bit_reg}}) & func_next) :
                   '0;
      bias_half <= bias_select & (common_count_select != MUX_STATIC)
                   & (common_count_select != MUX_QUAD);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_both_taken;
    do_wr;
  endsequence

  sequence s_resp_held;
    s_axi_bvalid && !s_axi_bready;
  endsequence

  AST_WR_RESP: assert property (s_both_taken |=> s_axi_bvalid)
    else $error("Write response did not follow the write.");

  AST_WR_HOLD: assert property (s_resp_held |=> s_axi_bvalid)
    else $error("Write response dropped before it was taken.");

  AST_FRAME_WRAP: assert property (
    (active_reg && tif.tick && last_com && waveform_type_select)
      |=> (com_idx_reg == 2'h0))
    else $error("Common count did not wrap at the selected last common.");

  AST_SHARED_PIN: assert property (
    (common_count_select == MUX_QUAD)
      && ($past(common_count_select) == MUX_QUAD)
      |-> !seg_pin_func[SEG_SHARED])
    else $error("Shared segment still driven with four commons.");

  AST_DRIVER_OFF: assert property (
    (!driver_on) [*2] |=> (com_select == 4'h0) && (seg_level == '0))
    else $error("Panel still driven after the driver was switched off.");

  AST_SLEEP_STOP: assert property (
    (driver_on && sleep_sync_reg[1] && sleep_disable) |=> !active_reg)
    else $error("Driver kept running in sleep with sleep-disable set.");

  AST_SLEEP_RUN: assert property (
    (driver_on && !sleep_disable) |=> active_reg)
    else $error("Driver stopped although sleep-disable is clear.");

  AST_WRITE_ERROR_FLAG_SET: assert property (
    (wr_pix && !write_allow_flag) |=> write_error_flag_reg)
    else $error("Rejected pixel write did not raise the error flag.");

  AST_PIX_STORE: assert property (
    (wr_pix && write_allow_flag)
      |=> (pix_reg[$past(wr_slot[4:0])] == $past(wr_data[7:0])))
    else $error("Allowed pixel write was not stored.");

  AST_ACTIVE_READ: assert property (
    (ar_hs && s_axi_araddr == OFS_PHASE)
      |=> (s_axi_rdata[PH_ACT_BIT] == $past(active_reg)))
    else $error("Active status bit read back wrong.");

  AST_TYPEA_STEP: assert property (
    (active_reg && tif.tick && !waveform_type_select && !phase_bit_reg)
      |=> phase_bit_reg && $stable(com_idx_reg))
    else $error("Type-A phase did not flip within the common.");

  AST_SEG_DATA: assert property (
    (active_reg && com_idx_reg == 2'h1 && func_next[0])
      |=> (seg_level[0] == ($past(pix_reg[3][0]) ^ $past(phase_bit_reg))))
    else $error("Segment zero does not follow its pixel for common one.");

endmodule : lcdd_ctrl
`default_nettype wire

// >>> lcdd_ctrl_test.sv
// Self-checking testbench for the segment LCD driver controller.
`timescale 1ns/1ps
`default_nettype none
module lcdd_ctrl_test;
  import lcdd_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = 4'hF, com_select;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic sleep_req = 0, timer_one_oscillator = 0, lfosc = 0, clr = 0;
  logic awready, wready, bvalid, arready, rvalid, com_phase, bias_half;
  logic [1:0] bresp, rresp;
  logic [SEG_W-1:0] seg_level, seg_pin_func;
  logic [1:0] bq [$];
  logic [41:0] rq [$];
  logic [41:0] e;
  logic [7:0] pix_sh [22];
  logic [7:0] se0, se1, se2;
  logic [3:0] r, c;
  int mismatches = 0, n_tests = 0, cyc = 0, t0, t, x;

  // Clocks; the oscillator inputs are unrelated to the bus clock.
  always #2.5 aclk = ~aclk;
  always #30 timer_one_oscillator = ~timer_one_oscillator;
  always #50 lfosc = ~lfosc;
  always @(posedge aclk) cyc <= cyc + 1;

  lcdd_ctrl u_lcdd_ctrl (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sleep_req(sleep_req),
    .timer_one_oscillator_clk(timer_one_oscillator), .lfosc_clk(lfosc), .com_select(com_select),
    .com_phase(com_phase), .seg_level(seg_level),
    .seg_pin_func(seg_pin_func), .bias_half(bias_half));

  lcdd_panel_model u_lcdd_panel_model (.aclk(aclk), .clr(clr),
    .com_select(com_select), .com_phase(com_phase), .seg_level(seg_level),
    .seg_pin_func(seg_pin_func));

  task automatic chk(input string what, input logic [33:0] ex,
                     input logic [33:0] got);
    n_tests++;
    if (got !== ex) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, ex, got);
    end
  endtask : chk

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  // Write: both halves offered together, each dropped once taken.
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] rs);
    bq.push_back(rs);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (!bvalid) @(posedge aclk);
    bready <= 1'b0;
  endtask : wr

  // Read; k masks bits whose value depends on the frame position.
  task automatic rd(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] rs, input logic [7:0] k = 8'hFF);
    rq.push_back({k, rs, 24'h0, d});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    rready <= 1'b0;
  endtask : rd

  // Bus answers are matched against the oldest note.
  always @(posedge aclk) begin
    if (bvalid && bready) chk("bresp", bq.pop_front(), bresp);
    if (rvalid && rready) begin
      e = rq.pop_front();
      chk("rdata", e[33:0], {rresp, rdata & {24'h0, e[41:34]}});
    end
  end

  function automatic logic [SEG_W-1:0] pf(input int m);
    return {se2[2:0], 8'h00, se1 & ((m == 3) ? 8'h7F : 8'hFF), se0};
  endfunction : pf

  function automatic logic [SEG_W-1:0] px(input int y, input int m);
    return {pix_sh[12+3*y][2:0], 8'h00, pix_sh[3*y+1], pix_sh[3*y]} & pf(m);
  endfunction : px

  task automatic wait_com();
    c = com_select;
    while (com_select === c) @(posedge aclk);
  endtask : wait_com

  // A hang still ends in the one closing task.
  initial begin
    #200us;
    mismatches++;
    summarize();
  end

  initial begin
    void'($urandom(77));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("com_idle", 0, com_select);
    chk("seg_idle", 0, seg_level);
    rd(OFS_CTRL, CTRL_RST, RESP_OKAY);
    rd(OFS_PHASE, PHASE_RST | 8'h10, RESP_OKAY);
    wr(8'h30, 8'hFF, RESP_SLVERR);
    rd(8'h30, 8'h00, RESP_SLVERR);
    wr(OFS_CTRL, 8'h3E, RESP_OKAY);
    rd(OFS_CTRL, 8'h0E, RESP_OKAY);
    wstrb <= 4'hE;
    wr(OFS_CTRL, 8'h03, RESP_OKAY);
    wstrb <= 4'hF;
    rd(OFS_CTRL, 8'h0E, RESP_OKAY);
    wr(OFS_PHASE, 8'hFF, RESP_OKAY);
    rd(OFS_PHASE, 8'hDF, RESP_OKAY);
    // Random pixels and segment enables, written while writes are allowed.
    for (int n = 0; n < 22; n++) begin
      if (n < 12 ? (n % 3 != 2) : (n % 3 == 0)) begin
        pix_sh[n] = (n < 12) ? 8'($urandom) : 8'($urandom % 8);
        wr(OFS_PIX_BASE + 8'(4 * n), pix_sh[n], RESP_OKAY);
        rd(OFS_PIX_BASE + 8'(4 * n), pix_sh[n], RESP_OKAY);
      end
    end
    se0 = 8'($urandom) | 8'h01;
    se1 = 8'($urandom) | 8'h80;
    se2 = 8'($urandom % 8);
    wr(OFS_SEGEN0, se0, RESP_OKAY);
    wr(OFS_SEGEN1, se1, RESP_OKAY);
    wr(OFS_SEGEN2, se2, RESP_OKAY);
    rd(OFS_SEGEN1, se1, RESP_OKAY);
    // Every common count, frame-step phase, half bias only where legal.
    for (int m = 0; m < 4; m++) begin
      x = (m == 1 || m == 2);
      wr(OFS_PHASE, x ? 8'hC0 : 8'h80, RESP_OKAY);
      wr(OFS_CTRL, 8'h80 | 8'(m), RESP_OKAY);
      repeat (4) @(posedge aclk);
      clr <= 1'b1;
      @(posedge aclk);
      clr <= 1'b0;
      repeat ((m + 1) * 512 + 100) @(posedge aclk);
      chk("commons", 4'hF >> (3 - m), u_lcdd_panel_model.visited);
      chk("bias", x, bias_half);
      chk("pin_func", pf(m), seg_pin_func);
      for (int y = 0; y <= m; y++) begin
        chk("pixels", px(y, m), u_lcdd_panel_model.seen[y]);
      end
      rd(OFS_PHASE, x ? 8'hE0 : 8'hA0, RESP_OKAY, 8'hEF);
    end
    // Pixel write in the blocked half of a static in-common phase frame.
    wr(OFS_PHASE, 8'h00, RESP_OKAY);
    wr(OFS_CTRL, 8'h80, RESP_OKAY);
    // Catch a rising phase, so the blocked half has most of its time left.
    while (com_phase !== 1'b0) @(posedge aclk);
    while (com_phase !== 1'b1) @(posedge aclk);
    repeat (20) @(posedge aclk);
    rd(OFS_PHASE, 8'h20, RESP_OKAY);
    wr(OFS_PIX_BASE, ~pix_sh[0], RESP_OKAY);
    rd(OFS_CTRL, 8'hA0, RESP_OKAY);
    rd(OFS_PIX_BASE, pix_sh[0], RESP_OKAY);
    wr(OFS_CTRL, 8'h80, RESP_OKAY);
    rd(OFS_CTRL, 8'h80, RESP_OKAY);
    // Sleep stops the driver only when sleep-disable is set.
    sleep_req <= 1'b1;
    wr(OFS_CTRL, 8'hC0, RESP_OKAY);
    repeat (8) @(posedge aclk);
    chk("com_sleep", 0, com_select);
    rd(OFS_PHASE, 8'h10, RESP_OKAY);
    wr(OFS_CTRL, 8'h80, RESP_OKAY);
    repeat (8) @(posedge aclk);
    chk("com_awake", 1, com_select);
    sleep_req <= 1'b0;
    // Step interval for each clock source and a random prescale.
    for (int s = 0; s < 3; s++) begin
      r = (s == 0) ? 4'($urandom % 4) : 4'($urandom % 16);
      wr(OFS_CTRL, 8'h00, RESP_OKAY);
      wr(OFS_PHASE, {4'h8, r}, RESP_OKAY);
      wr(OFS_CTRL, 8'h81 | 8'(s << 2), RESP_OKAY);
      // The first change is the start, the second the first full step.
      wait_com();
      wait_com();
      t0 = cyc;
      repeat (4) wait_com();
      t = cyc - t0;
      x = 4 * (r + 1) * ((s == 0) ? 256 : (s == 1) ? 12 : 20);
      chk("interval", x, (t >= x - 3 && t <= x + 3) ? x : t);
    end
    summarize();
  end
endmodule : lcdd_ctrl_test
`default_nettype wire

// >>> lcdd_panel_model.sv
// Passive segment LCD glass model that records the pixels per common.
`timescale 1ns/1ps
`default_nettype none
module lcdd_panel_model
  import lcdd_pkg::*;
(
  input wire logic aclk,
  input wire logic clr,
  input wire logic [3:0] com_select,
  input wire logic com_phase,
  input wire logic [SEG_W-1:0] seg_level,
  input wire logic [SEG_W-1:0] seg_pin_func
);
  logic [SEG_W-1:0] seen [4];
  logic [3:0] visited;

  // The phase is undone here, so a wrong inversion shows as a wrong pixel.
  always @(posedge aclk) begin
    // The bench clears the record through a pin, so only one process
    // ever writes it.
    visited <= clr ? 4'h0 : (visited | com_select);
    for (int y = 0; y < 4; y++) begin
      if (com_select == (4'h1 << y)) begin
        seen[y] <= (seg_level ^ {SEG_W{com_phase}}) & seg_pin_func;
      end
    end
  end
endmodule : lcdd_panel_model
`default_nettype wire

// >>> lcdd_pkg.sv
// Shared constants for the segment LCD driver controller.
package lcdd_pkg;

  // Bus, array and divider dimensions.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SEG_W = 27;
  localparam int PIX_COUNT = 24;
  localparam int FOSC_DIV_W = 8;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PHASE = 8'h04;
  localparam logic [7:0] OFS_SEGEN0 = 8'h08;
  localparam logic [7:0] OFS_SEGEN1 = 8'h0C;
  localparam logic [7:0] OFS_SEGEN2 = 8'h10;
  localparam logic [7:0] OFS_PIX_BASE = 8'h40;

  // Reset values and writable-bit masks.
  localparam logic [7:0] CTRL_RST = 8'h03;
  localparam logic [7:0] PHASE_RST = 8'h03;
  localparam logic [7:0] SEGEN_RST = 8'h00;
  localparam logic [7:0] PIX_RST = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'hCF;
  localparam logic [7:0] PHASE_WMASK = 8'hCF;

  // Field positions of the main control register.
  localparam int CTRL_ON_BIT = 7;
  localparam int CTRL_SLPDIS_BIT = 6;
  localparam int CTRL_WRITE_ERROR_FLAG_BIT = 5;
  localparam int CTRL_CS_LSB = 2;
  localparam int CTRL_MUX_LSB = 0;

  // Field positions of the phase and prescale register.
  localparam int PH_WFT_BIT = 7;
  localparam int PH_BIAS_BIT = 6;
  localparam int PH_ACT_BIT = 5;
  localparam int PH_WA_BIT = 4;
  localparam int PH_LP_LSB = 0;

  // Encodings.
  localparam logic [1:0] SRC_FOSC = 2'h0;
  localparam logic [1:0] SRC_TIMER_ONE_OSCILLATOR = 2'h1;
  localparam logic [1:0] MUX_STATIC = 2'h0;
  localparam logic [1:0] MUX_QUAD = 2'h3;
  localparam int SEG_SHARED = 15;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : lcdd_pkg

// >>> lcdd_tick_gen.sv
// LCD clock source selection and prescaler producing step ticks.
`timescale 1ns/1ps
`default_nettype none
module lcdd_tick_gen
  import lcdd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic timer_one_oscillator_clk,
  input wire logic lfosc_clk,
  lcdd_tick_if.gen tif
);

  logic [1:0] t1_sync_reg;
  logic [1:0] lf_sync_reg;
  logic t1_prev_reg;
  logic lf_prev_reg;
  logic [FOSC_DIV_W-1:0] div_reg;
  logic [3:0] pre_reg;
  logic tick_reg;
  logic src_edge;
  logic [4:0] edge_cnt_reg;
  logic track_reg;

  // Slow oscillators are asynchronous to aclk, so each passes two flops.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      t1_sync_reg <= 2'h0;
      lf_sync_reg <= 2'h0;
      t1_prev_reg <= 1'b0;
      lf_prev_reg <= 1'b0;
    end else begin
      t1_sync_reg <= {t1_sync_reg[0], timer_one_oscillator_clk};
      lf_sync_reg <= {lf_sync_reg[0], lfosc_clk};
      t1_prev_reg <= t1_sync_reg[1];
      lf_prev_reg <= lf_sync_reg[1];
    end
  end

  // Free-running divide-by-256 of the system clock.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  // One source edge per selected clock period.
  always_comb begin
    case (tif.src_sel)
      SRC_FOSC: src_edge = (div_reg == 8'hFF);
      SRC_TIMER_ONE_OSCILLATOR: src_edge = t1_sync_reg[1] & ~t1_prev_reg;
      default: src_edge = lf_sync_reg[1] & ~lf_prev_reg;
    endcase
  end

  // Divide by ratio plus one; held clear while the driver is idle.
  always_ff @(posedge aclk) begin
    if (!aresetn || !tif.run) begin
      pre_reg <= 4'h0;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= 1'b0;
      if (src_edge) begin
        if (pre_reg == tif.ratio) begin
          pre_reg <= 4'h0;
          tick_reg <= 1'b1;
        end else begin
          pre_reg <= pre_reg + 4'h1;
        end
      end
    end
  end

  assign tif.tick = tick_reg;

  // Edge count between ticks, valid only while the ratio stayed put.
  always_ff @(posedge aclk) begin
    if (!aresetn || !tif.run || (tif.ratio != $past(tif.ratio))) begin
      edge_cnt_reg <= 5'h00;
      track_reg <= 1'b0;
    end else if (tick_reg) begin
      edge_cnt_reg <= {4'h0, src_edge};
      track_reg <= 1'b1;
    end else if (src_edge) begin
      edge_cnt_reg <= edge_cnt_reg + 5'h01;
    end
  end

  AST_PRESCALE_RATIO: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (tick_reg && track_reg && tif.run && $stable(tif.ratio))
      |-> (edge_cnt_reg == ({1'b0, tif.ratio} + 5'h01)))
    else $error("Tick spacing does not match the prescale ratio.");

  AST_FOSC_SPACING: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (src_edge && tif.src_sel == SRC_FOSC)
      |=> (!src_edge || tif.src_sel != SRC_FOSC) [*8])
    else $error("System clock divider edges come too close.");

endmodule : lcdd_tick_gen
`default_nettype wire

// >>> lcdd_tick_if.sv
// Link between the register block and the LCD tick generator.
`timescale 1ns/1ps
`default_nettype none
interface lcdd_tick_if;
  logic [1:0] src_sel;
  logic [3:0] ratio;
  logic run;
  logic tick;
  modport ctl (output src_sel, output ratio, output run, input tick);
  modport gen (input src_sel, input ratio, input run, output tick);
endinterface : lcdd_tick_if
`default_nettype wire
